/* adc_serial_command_sequencer.sv */
/*
 * Serial command sequencer of a sensor converter: link slave in clock
 * mode 1, opcode decode, configuration store, result readout and
 * data-ready signalling.
 * Assumes link pins asynchronous to clk_sys and a link clock at least
 * eight times slower; results arrive on a valid/ready stream.
 */
`include "adc_seq_defs.svh"

module adc_serial_command_sequencer (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic din,
	output logic shared_data_out_ready,
	output logic shared_data_out_ready_oe,
	output logic data_ready_n,
	input wire logic [`DATA_W-1:0] sample_data,
	input wire logic sample_valid,
	output logic sample_ready,
	output logic [31:0] config_out,
	output adc_seq_pkg::status_t status
);
	import adc_seq_pkg::*;

	logic [2:0] sy1_ff;
	logic [2:0] sy2_ff;
	logic [2:0] prev_ff;
	logic [2:0] rx_cnt_ff;
	logic [6:0] rx_sh_ff;
	seq_state_t state_ff;
	logic [1:0] wr_idx_ff;
	logic [23:0] wr_sh_ff;
	logic [31:0] cfg_ff;
	logic [`BUSY_W-1:0] busy_cnt_ff;
	logic converting_ff;
	logic powered_down_ff;
	logic amp_enabled_ff;
	logic inputs_shorted_ff;
	logic loaded_ff;
	logic rd_cfg_ff;
	logic [5:0] out_cnt_ff;
	logic [31:0] out_sh_ff;
	logic dout_ff;
	logic dout_oe_ff;
	logic ready_n_ff;
	status_t status_ff;
	logic fifo_valid;
	logic fifo_in_ready;
	logic [`DATA_W-1:0] fifo_data;

	// synchronised pins and link clock edges
	wire cs_s = sy2_ff[0];
	wire din_s = sy2_ff[2];
	wire active = ~cs_s;
	wire sclk_rise = active & sy2_ff[1] & ~prev_ff[1];
	wire sclk_fall = active & ~sy2_ff[1] & prev_ff[1];
	wire cs_rise = sy2_ff[0] & ~prev_ff[0];

	// byte assembly and opcode decode
	wire byte_done = sclk_fall & (rx_cnt_ff == 3'd7);
	wire [7:0] rx_byte = {rx_sh_ff, din_s};
	wire busy_w = busy_cnt_ff != '0;
	wire cmd_ok = byte_done & ~busy_w & (state_ff == ST_CMD);
	wire is_reset = cmd_ok & (rx_byte == `OP_RESET);
	wire is_wrcfg = cmd_ok & (rx_byte == `OP_WRCFG);
	wire is_rdcfg = cmd_ok & (rx_byte == `OP_RDCFG);
	wire is_start = cmd_ok & (rx_byte == `OP_START);
	wire is_sleep = cmd_ok & (rx_byte == `OP_SLEEP);
	wire wr_byte = byte_done & ~busy_w & (state_ff == ST_WR);
	wire wr_last = wr_byte & (wr_idx_ff == 2'd3);

	// configuration fields and derived controls
	wire cont_mode = cfg_ff[`CFG_CONT];
	wire ready_mode = cfg_ff[`CFG_RDY_MODE];
	wire [2:0] gain_code = cfg_ff[`CFG_GAIN_HI:`CFG_GAIN_LO];
	wire [3:0] sel_code = cfg_ff[`CFG_SEL_HI:`CFG_SEL_LO];
	wire nxt_amp_en = ~cfg_ff[`CFG_BYPASS] | (gain_code > `GAIN_MAX_BYPASS);

	// result path: capture while converting, load at a byte boundary
	wire push = sample_valid & fifo_in_ready & converting_ff;
	wire load_w = active & ~loaded_ff & ~busy_w & fifo_valid
		& (state_ff == ST_CMD) & (rx_cnt_ff == 3'd0);
	wire [5:0] out_len = rd_cfg_ff ? `CFG_BITS : `RESULT_BITS;
	wire out_done = loaded_ff & sclk_fall & (out_cnt_ff == out_len);
	// a result leaves the fifo only once all its bits went out
	wire result_taken = out_done & ~rd_cfg_ff;
	wire result_held = loaded_ff & ~rd_cfg_ff;
	wire waiting = fifo_valid & ~result_held & ~load_w;

	// top-level outputs, all from flops
	assign shared_data_out_ready = dout_ff;
	assign shared_data_out_ready_oe = dout_oe_ff;
	assign data_ready_n = ready_n_ff;
	assign config_out = cfg_ff;
	assign status = status_ff;
	assign sample_ready = fifo_in_ready;

	// two-stage synchronisers for select, clock and data
	always_ff @(posedge clk_sys)
	begin
		sy1_ff <= {din, sclk, cs_n};
		sy2_ff <= rst ? 3'h1 : sy1_ff; // idle: deselected, clock low
		prev_ff <= rst ? 3'h1 : sy2_ff;
	end

	// input shift on falling edges; deselect clears it
	always_ff @(posedge clk_sys)
	begin
		if (rst || !active)
		begin
			rx_cnt_ff <= 3'h0;
			rx_sh_ff <= 7'h00;
		end
		else if (sclk_fall)
		begin
			rx_cnt_ff <= 3'(rx_cnt_ff + 1'b1);
			rx_sh_ff <= rx_byte[6:0];
		end
	end

	// command state and write byte index
	always_ff @(posedge clk_sys)
	begin
		if (rst || !active)
			state_ff <= ST_CMD;
		else if (is_wrcfg)
			state_ff <= ST_WR;
		else if (wr_last)
			state_ff <= ST_CMD;
		if (rst || !active || is_wrcfg)
			wr_idx_ff <= 2'd0;
		else if (wr_byte)
			wr_idx_ff <= 2'(wr_idx_ff + 1'b1);
	end

	// configuration store, committed after the fourth byte
	always_ff @(posedge clk_sys)
	begin
		if (rst || is_reset)
			cfg_ff <= `CFG_RESET;
		else if (wr_last)
			cfg_ff <= {wr_sh_ff, rx_byte};
		if (rst)
			wr_sh_ff <= 24'h000000;
		else if (wr_byte)
			wr_sh_ff <= {wr_sh_ff[15:0], rx_byte};
	end

	// wait after power-up or reset opcode; commands ignored meanwhile
	always_ff @(posedge clk_sys)
	begin
		if (rst || is_reset)
			busy_cnt_ff <= `BUSY_W'(`RESET_WAIT_CYC);
		else if (busy_w)
			busy_cnt_ff <= `BUSY_W'(busy_cnt_ff - 1'b1);
	end

	// conversion and power-down control; start wins over a clear
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			converting_ff <= 1'b0;
		else if (is_start)
			converting_ff <= 1'b1;
		else if (is_sleep || is_reset || (push && !cont_mode))
			converting_ff <= 1'b0;
		if (rst || is_reset || is_start)
			powered_down_ff <= 1'b0;
		else if (is_sleep)
			powered_down_ff <= 1'b1;
	end

	// amplifier and input selection decode
	always_ff @(posedge clk_sys)
	begin
		amp_enabled_ff <= rst ? 1'b1 : nxt_amp_en;
		inputs_shorted_ff <= ~rst & (sel_code == `SEL_SHORTED);
	end

	// output shift register: result or configuration readout
	always_ff @(posedge clk_sys)
	begin
		if (rst || !active)
		begin
			loaded_ff <= 1'b0;
			rd_cfg_ff <= 1'b0;
			out_cnt_ff <= 6'd0;
			out_sh_ff <= 32'h0000_0000;
		end
		else if (is_rdcfg)
		begin
			loaded_ff <= 1'b1;
			rd_cfg_ff <= 1'b1;
			out_cnt_ff <= 6'd0;
			out_sh_ff <= cfg_ff;
		end
		else if (load_w)
		begin
			loaded_ff <= 1'b1;
			rd_cfg_ff <= 1'b0;
			out_cnt_ff <= 6'd0;
			out_sh_ff <= {fifo_data, 16'h0000};
		end
		else if (out_done)
			loaded_ff <= 1'b0;
		else if (loaded_ff && sclk_rise)
		begin
			out_cnt_ff <= 6'(out_cnt_ff + 1'b1);
			out_sh_ff <= {out_sh_ff[30:0], 1'b0};
		end
	end

	// shared data pin: shifted bit, or ready indication when idle
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			dout_ff <= 1'b1;
		else if (loaded_ff && sclk_rise)
			dout_ff <= out_sh_ff[31];
		else if (!loaded_ff)
			dout_ff <= ready_mode ? ready_n_ff : 1'b1;
		dout_oe_ff <= ~rst & active;
	end

	// data ready: low while an unread result waits, high once it is loaded for readout
	always_ff @(posedge clk_sys)
	begin
		ready_n_ff <= rst | ~waiting;
		status_ff <= rst ? '0 : {busy_w, converting_ff, powered_down_ff,
			amp_enabled_ff, inputs_shorted_ff};
	end

	result_fifo #(.WIDTH(`DATA_W), .DEPTH(`FIFO_DEPTH)) u_fifo (
		.clk_sys(clk_sys),
		.rst(rst),
		.flush(is_reset),
		.in_valid(sample_valid & converting_ff),
		.in_ready(fifo_in_ready),
		.in_data(sample_data),
		.out_valid(fifo_valid),
		.out_ready(result_taken),
		.out_data(fifo_data)
	);

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	a_reset_busy: assert property (is_reset |=> busy_w [*8])
		else $error("reset opcode did not start the wait");
	a_write_commit: assert property (wr_last |=>
		cfg_ff == {$past(wr_sh_ff), $past(rx_byte)})
		else $error("configuration write not stored");
	a_read_config: assert property (is_rdcfg |=>
		loaded_ff && out_sh_ff == $past(cfg_ff))
		else $error("configuration readout not loaded");
	a_start_conv: assert property (is_start |=> converting_ff)
		else $error("start opcode did not start conversion");
	a_deselect_clear: assert property (cs_rise |=>
		state_ff == ST_CMD && !loaded_ff && rx_cnt_ff == 3'd0)
		else $error("deselect did not reset the interface");
	a_ready_low: assert property (waiting
		|=> !ready_n_ff)
		else $error("data ready not low with a result waiting");
	a_result_load: assert property (load_w |=>
		out_sh_ff[31:16] == $past(fifo_data) && !rd_cfg_ff)
		else $error("result not loaded msb first");
	a_sleep_stop: assert property (is_sleep && !is_start |=>
		!converting_ff && powered_down_ff)
		else $error("sleep opcode did not stop conversion");
	a_gain_amp: assert property (gain_code > `GAIN_MAX_BYPASS
		|=> amp_enabled_ff)
		else $error("high gain without amplifier");
	a_short_sel: assert property (sel_code == `SEL_SHORTED
		|=> inputs_shorted_ff)
		else $error("shorted input pattern not decoded");
	a_shared_ready: assert property (!loaded_ff && ready_mode
		|=> dout_ff == $past(ready_n_ff))
		else $error("shared pin does not show data ready");
	a_dout_stable: assert property (loaded_ff && !sclk_rise
		|=> $stable(dout_ff))
		else $error("data out changed off a rising edge");
	a_ready_release: assert property (load_w |=> ready_n_ff)
		else $error("data ready not released at readout");
endmodule

/* adc_seq_defs.svh */
/*
 * Constants of the serial command sequencer: opcodes, configuration
 * field positions, reset values and timing counts.
 * Assumes a 25 MHz system clock and a link clock well below it.
 */
// Notes on behaviour
// - opcode 06h resets the device; host then waits 50 us plus 32 clocks.
// - opcode 43h is followed by four configuration bytes that get stored.
// - opcode 23h returns all configuration registers on the serial output.
// - opcode 08h starts conversions; continuous mode keeps producing results.
// - host waits before deselect; rising chip select resets the interface.
// - a new result drives data_ready_n low; host waits for that edge.
// - sixteen clock rising edges in one frame shift the result out.
// - opcode 02h stops conversions and enters power-down.
// - with amplifier bypass only gains 1, 2, 4; higher gains enable it.
// - input selector pattern 1110 shorts both inputs at mid-supply.
// - ready pin mode 1 also signals readiness on the shared data pin.
// - outgoing data changes on rising edges, incoming sampled on falling.
`ifndef ADC_SEQ_DEFS_SVH
`define ADC_SEQ_DEFS_SVH

`define OP_RESET 8'h06
`define OP_WRCFG 8'h43
`define OP_RDCFG 8'h23
`define OP_START 8'h08
`define OP_SLEEP 8'h02

// configuration word, first written byte in bits 31:24
`define CFG_RESET 32'h0000_0000
`define CFG_SEL_HI 31
`define CFG_SEL_LO 28
`define CFG_GAIN_HI 27
`define CFG_GAIN_LO 25
`define CFG_BYPASS 24
`define CFG_CONT 18
`define CFG_RDY_MODE 1
`define SEL_SHORTED 4'hE
`define GAIN_MAX_BYPASS 3'h2

`define DATA_W 16
`define FIFO_DEPTH 8
`define RESULT_BITS 6'd16
`define CFG_BITS 6'd32

// wait after reset: 50 us plus 32 internal clock periods
`define CLK_SYS_NS 40
`define RESET_WAIT_US 50
`define INT_CLK_NS 250
`define INT_CLK_COUNT 32
`define RESET_WAIT_CYC ((`RESET_WAIT_US * 1000 + `INT_CLK_COUNT * \
	`INT_CLK_NS + `CLK_SYS_NS - 1) / `CLK_SYS_NS)
`define BUSY_W 11

`endif

/* adc_seq_pkg.sv */
/*
 * Types of the serial command sequencer.
 * Assumes nothing beyond the constants header.
 */
package adc_seq_pkg;
	// serial command state
	typedef enum logic [0:0] {ST_CMD, ST_WR} seq_state_t;

	// device status carried to the user side
	typedef struct packed {
		logic busy;
		logic converting;
		logic powered_down;
		logic amp_enabled;
		logic inputs_shorted;
	} status_t;
endpackage

/* result_fifo.sv */
/*
 * Synchronous FIFO for conversion results, valid and ready on both sides.
 * Assumes one clock and a synchronous active-high reset.
 */
module result_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic flush,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_ff;
	logic [AW-1:0] rd_ptr_ff;
	logic [AW:0] count_ff;
	logic in_ready_ff;
	logic out_valid_ff;
	wire push = in_valid & in_ready_ff;
	wire pop = out_valid_ff & out_ready;
	wire [AW:0] nxt_count = (AW+1)'(count_ff + {{AW{1'b0}}, push}
		- {{AW{1'b0}}, pop});

	// handshake outputs
	assign in_ready = in_ready_ff;
	assign out_valid = out_valid_ff;
	assign out_data = mem[rd_ptr_ff];

	// storage
	always_ff @(posedge clk_sys)
	begin
		if (push)
			mem[wr_ptr_ff] <= in_data;
	end

	// pointers and fill level
	always_ff @(posedge clk_sys)
	begin
		if (rst || flush)
		begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff <= '0;
			in_ready_ff <= 1'b1;
			out_valid_ff <= 1'b0;
		end
		else
		begin
			wr_ptr_ff <= push ? AW'(wr_ptr_ff + 1'b1) : wr_ptr_ff;
			rd_ptr_ff <= pop ? AW'(rd_ptr_ff + 1'b1) : rd_ptr_ff;
			count_ff <= nxt_count;
			in_ready_ff <= nxt_count != (AW+1)'(DEPTH);
			out_valid_ff <= nxt_count != '0;
		end
	end
endmodule

/* host_link_model.sv */
/*
 host side of the link: a clock mode 1 master driving framed transfers.
 assumes clk_sys at 25 MHz; a link half period is four system cycles.
*/
module host_link_model (
	input wire logic clk_sys,
	output logic cs_n,
	output logic sclk,
	output logic din,
	input wire logic dout
);
	timeunit 1ns;
	timeprecision 1ps;

	// idle: deselected under own control, clock low
	initial
	begin
		cs_n = 1'b1;
		sclk = 1'b0;
		din = 1'b1;
	end

	// wait a number of system clocks
	task automatic hold(input int n);
		repeat (n) @(posedge clk_sys);
	endtask

	// one frame of n bits, msb first; rx collects the device's output
	task automatic frame(input int n, input logic [39:0] tx,
		output logic [39:0] rx);
		rx = '0;
		@(posedge clk_sys);
		cs_n <= 1'b0;
		hold(4);
		for (int i = n - 1; i >= 0; i--)
		begin
			sclk <= 1'b1;
			din <= tx[i]; // launch on rising edge
			hold(4);
			sclk <= 1'b0;
			rx = {rx[38:0], dout}; // sample on falling edge
			hold(4);
		end
		hold(4);
		cs_n <= 1'b1;
		din <= ~din; // released line keeps no stale level
		hold(8);
	endtask
endmodule

/* adc_serial_command_sequencer_tb.sv */
/*
 self-checking bench of the serial command sequencer.
 assumes the host model drives the link and the bench the result stream.
*/
`include "adc_seq_defs.svh"

module adc_serial_command_sequencer_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import adc_seq_pkg::*;

	logic clk_sys, rst, cs_n, sclk, din, dout, dout_oe, data_ready_n;
	logic [15:0] sample_data;
	logic sample_valid, sample_ready;
	logic [31:0] config_out;
	status_t status;
	logic [39:0] rx;
	int err_total, samples_checked, cycles;

	adc_serial_command_sequencer DUT (
		.clk_sys(clk_sys),
		.rst(rst),
		.cs_n(cs_n),
		.sclk(sclk),
		.din(din),
		.shared_data_out_ready(dout),
		.shared_data_out_ready_oe(dout_oe),
		.data_ready_n(data_ready_n),
		.sample_data(sample_data),
		.sample_valid(sample_valid),
		.sample_ready(sample_ready),
		.config_out(config_out),
		.status(status)
	);

	host_link_model host (
		.clk_sys(clk_sys),
		.cs_n(cs_n),
		.sclk(sclk),
		.din(din),
		.dout(dout)
	);

	// 25 MHz clock
	always #20 clk_sys = ~clk_sys;

	// hang guard
	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == 60000)
		begin
			err_total++;
			end_sim();
		end
	end

	task automatic end_sim();
		$display("errors %0d checks %0d", err_total, samples_checked);
		if (err_total == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic check(input logic [39:0] got, exp, input string what);
		samples_checked++;
		if (got !== exp)
		begin
			err_total++;
			$display("wrong value at %0t: %s got %h exp %h", $time, what,
				got, exp);
		end
	endtask

	task automatic cmd(input logic [7:0] op);
		host.frame(8, {32'h0000_0000, op}, rx);
	endtask

	task automatic wr_cfg(input logic [31:0] w);
		host.frame(40, {`OP_WRCFG, w}, rx);
		check(config_out, w, "config");
	endtask

	// offer one result, held while sample_ready is low, up to 50 clocks
	task automatic push(input logic [15:0] d);
		@(posedge clk_sys);
		sample_data <= d;
		sample_valid <= 1'b1;
		for (int i = 0; i < 50 && sample_ready !== 1'b1; i++)
			@(negedge clk_sys);
		@(posedge clk_sys);
		sample_valid <= 1'b0;
	endtask

	task automatic t_power_up();
		host.hold(2);
		check({dout_oe, data_ready_n}, 2'b01, "idle pins");
		check(config_out, 32'h0000_0000, "config reset");
		host.hold(1430);
		check(status.busy, 1'b1, "busy");
		host.hold(30);
		check(status.busy, 1'b0, "busy done");
	endtask

	task automatic t_config();
		wr_cfg(32'h0804_1000);
		host.frame(40, {`OP_RDCFG, 32'h0000_0000}, rx);
		check(rx[31:0], 32'h0804_1000, "readback");
		wr_cfg(32'hE500_0000);
		check({status.amp_enabled, status.inputs_shorted}, 2'b01, "byp");
		wr_cfg(32'h0700_0000);
		check({status.amp_enabled, status.inputs_shorted}, 2'b10, "amp");
	endtask

	task automatic t_stream();
		wr_cfg(32'h0804_1002);
		cmd(`OP_START);
		check(status.converting, 1'b1, "converting");
		for (int i = 0; i < 8; i++)
			push(16'h8C31 + 16'(i));
		host.hold(4);
		check(sample_ready, 1'b0, "fifo full");
		check(data_ready_n, 1'b0, "ready low");
		check(dout, 1'b0, "shared pin ready");
		for (int i = 0; i < 8; i++)
		begin
			host.frame(16, '0, rx);
			check(rx[15:0], 16'h8C31 + 16'(i), "result");
		end
		check(data_ready_n, 1'b1, "ready released");
		check(dout, 1'b1, "shared pin idle");
	endtask

	// host offset calibration: average shorted readings, subtract
	task automatic t_offset();
		int sum;
		int avg;
		sum = 0;
		wr_cfg(32'hE004_1000);
		check({status.amp_enabled, status.inputs_shorted}, 2'b11, "short");
		cmd(`OP_START);
		push(16'hFFFE);
		push(16'h0004);
		push(16'hFFFA);
		push(16'h0000);
		for (int i = 0; i < 4; i++)
		begin
			host.frame(16, '0, rx);
			sum += int'($signed(rx[15:0]));
		end
		avg = sum / 4;
		check(40'(avg), 40'hFF_FFFF_FFFF, "offset average");
		wr_cfg(32'h0004_1000);
		push(16'h0100);
		host.frame(16, '0, rx);
		check(40'(int'($signed(rx[15:0])) - avg), 40'd257, "corrected");
	endtask

	// reset in mid-run: pins and state at the first two edges after it
	task automatic t_mid_reset();
		wr_cfg(32'h0804_1002);
		@(posedge clk_sys);
		rst <= 1'b1;
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		check({dout, dout_oe, data_ready_n}, 3'b101, "pins after reset");
		check({status, config_out}, 37'h0, "state after reset");
		@(posedge clk_sys);
		check(status, 5'h12, "busy after reset");
		host.hold(1460);
		check(status.busy, 1'b0, "busy cleared");
	endtask

	task automatic t_sleep();
		cmd(`OP_SLEEP);
		check({status.converting, status.powered_down}, 2'b01, "sleep");
		push(16'h1234);
		host.hold(4);
		check(data_ready_n, 1'b1, "no result");
	endtask

	task automatic t_reset_cmd();
		wr_cfg(32'h0804_1000);
		cmd(`OP_RESET);
		check({status.busy, config_out}, 33'h1_0000_0000, "reset op");
		host.hold(1460);
		check(status.busy, 1'b0, "reset wait");
	endtask

	// reset, then the scenarios in turn
	initial
	begin
		clk_sys = 1'b0;
		rst = 1'b1;
		sample_valid = 1'b0;
		sample_data = '0;
		err_total = 0;
		samples_checked = 0;
		cycles = 0;
		repeat (10) @(posedge clk_sys);
		rst <= 1'b0;
		t_power_up();
		t_config();
		t_stream();
		t_offset();
		t_sleep();
		t_reset_cmd();
		t_mid_reset();
		end_sim();
	end
endmodule
